/* rtl/flash_seq_pkg.sv */
// Constants of the flash self-programming sequencer.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
package flash_seq_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int PSE_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int FREAD_BIT = 3;
  localparam int BCLR_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [CTRL_W-1:0] PAT_BCLR = 5'h11;
  localparam logic [CTRL_W-1:0] PAT_FREAD = 5'h09;
  localparam logic [CTRL_W-1:0] PAT_WRITE = 5'h05;
  localparam logic [CTRL_W-1:0] PAT_ERASE = 5'h03;
  localparam logic [CTRL_W-1:0] PAT_LOAD = 5'h01;

  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EE_BIT = 1;
  localparam int ST_WIN_BIT = 2;

  // ----------------------------------------------------------------
  // Enable windows, in clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] LPM_WIN = 3'h3;

  // ----------------------------------------------------------------
  // Pointer layout and fuse addresses
  // ----------------------------------------------------------------
  localparam int PTR_W = 16;
  localparam int PAGE_WORD_BITS = 5;
  localparam int PAGE_W = PTR_W - PAGE_WORD_BITS - 1;
  localparam logic [PTR_W-1:0] PTR_FUSE_LO = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_LOCK = 16'h0001;
  localparam logic [PTR_W-1:0] PTR_FUSE_HI = 16'h0003;
  localparam logic [7:0] UNPROG_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Programming time
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_MIN_NS = 3_700_000;
  localparam int PROG_MAX_NS = 4_500_000;
  localparam int RC_PERIOD_NS = 125;
  localparam int TMR_W = 20;
  localparam int PROG_MAX_CYC_DEF = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int PROG_RC_TICKS_DEF = (PROG_MIN_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* rtl/self_program_flash_sequencer.sv */
// Self-programming sequencer for on-chip program flash: control register,
// enable windows, page load/erase/write and fuse/lock readback.
// Assumes the CPU, EEPROM controller and page buffer run on ref_clk_i;
// rc_clk_i and the fuse levels come from outside and are synchronised.
//
// Contract
// - Write plus enable armed, store in four cycles writes buffer to page.
// - Page operations take page from pointer high bits, ignore data pair.
// - Page-write bit clears at completion or after four idle cycles.
// - Erase plus enable armed, store in four cycles erases addressed page.
// - Page-erase bit clears at completion or after four idle cycles.
// - CPU stalled for entire page erase or page write.
// - Enable opens a four-cycle store window; companion bit picks the action.
// - Enable alone: store writes data pair into buffer word, pointer LSB ignored.
// - Enable clears after store or four idle cycles; held during page operations.
// - Only the five listed low-bit patterns act; others are ignored.
// - EEPROM write blocks flash programming and fuse/lock reads.
// - Pointer 0x0001 with fuse read armed: load in three cycles returns lock bits.
// - Fuse read and enable clear after read, three-cycle or four-cycle timeout.
// - Pointer 0x0000 with fuse read armed returns fuse low byte.
// - Pointer 0x0003 with fuse read armed returns fuse high byte.
// - Programmed fuse or lock bits read zero, unprogrammed read one.
// - A flash write in progress completes despite reset.
// - Flash operation timed by RC oscillator, lasting 3.7ms to 4.5ms.
// - Buffer-clear write empties the temporary page buffer.
// - Buffer erased after each page write and after reset.
// - Control register top three bits read as zero.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module self_program_flash_sequencer
  import flash_seq_pkg::*;
#(
  parameter logic [TMR_W-1:0] PROG_RC_TICKS = TMR_W'(PROG_RC_TICKS_DEF),
  parameter logic [TMR_W-1:0] PROG_MAX_CYC = TMR_W'(PROG_MAX_CYC_DEF)
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  output logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_wready_o,
  output logic s_axi_bvalid_o,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_arready_o,
  output logic s_axi_rvalid_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rready_i,
  // CPU side
  input wire logic store_program_instr_i,
  input wire logic load_program_instr_i,
  input wire logic [PTR_W-1:0] pointer_i,
  input wire logic [15:0] data_word_pair_i,
  input wire logic eeprom_write_busy_i,
  output logic cpu_stall_o,
  output logic load_valid_o,
  output logic [7:0] load_data_o,
  // Temporary page buffer
  output logic buf_wr_o,
  output logic [PAGE_WORD_BITS-1:0] buf_word_o,
  output logic [15:0] buf_data_o,
  output logic buf_clear_o,
  // Flash array
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [PAGE_W-1:0] flash_page_o,
  // Oscillator and fuse storage (1 = programmed)
  input wire logic rc_clk_i,
  input wire logic [7:0] fuse_low_prog_i,
  input wire logic [7:0] fuse_high_prog_i,
  input wire logic [7:0] lock_prog_i
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [24:0] sync1_ff;
  logic [24:0] sync2_ff;
  logic rc_prev_ff;

  always_ff @(posedge ref_clk_i) begin
    sync1_ff <= {rc_clk_i, lock_prog_i, fuse_high_prog_i, fuse_low_prog_i};
    sync2_ff <= sync1_ff;
    rc_prev_ff <= sync2_ff[24];
  end

  wire logic rc_tick = sync2_ff[24] & ~rc_prev_ff;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;
  logic [2:0] win_cnt_ff;
  logic busy_ff, op_write_ff;
  logic [PAGE_W-1:0] page_ff;
  logic [TMR_W-1:0] rc_cnt_ff, cyc_cnt_ff;
  logic buf_wr_ff, buf_clear_ff, load_valid_ff;
  logic [PAGE_WORD_BITS-1:0] buf_word_ff;
  logic [15:0] buf_data_ff;
  logic [7:0] load_data_ff;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire logic aw_take = s_axi_awvalid_i & awready_ff;
  wire logic w_take = s_axi_wvalid_i & wready_ff;
  wire logic wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire logic wr_ctrl_hit = awaddr_ff == CTRL_OFS;
  wire logic wr_stat_hit = awaddr_ff == STAT_OFS;
  wire logic wr_mapped = wr_ctrl_hit | wr_stat_hit;
  wire logic [CTRL_W-1:0] wr_pat = wdata_ff[CTRL_W-1:0];
  wire logic nxt_aw_held = (aw_held_ff | aw_take) & ~wr_fire;
  wire logic nxt_w_held = (w_held_ff | w_take) & ~wr_fire;
  wire logic nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready_i);

  wire logic pat_ok = (wr_pat == PAT_BCLR) | (wr_pat == PAT_FREAD) |
                      (wr_pat == PAT_WRITE) | (wr_pat == PAT_ERASE) |
                      (wr_pat == PAT_LOAD);

  // ----------------------------------------------------------------
  // Read channel decode
  // ----------------------------------------------------------------
  wire logic ar_take = s_axi_arvalid_i & arready_ff;
  wire logic rd_ctrl_hit = s_axi_araddr_i == CTRL_OFS;
  wire logic rd_stat_hit = s_axi_araddr_i == STAT_OFS;
  wire logic nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready_i);
  wire logic win_open = ctrl_ff[PSE_BIT] & ~busy_ff;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_BUSY_BIT] = busy_ff;
    stat_word[ST_EE_BIT] = eeprom_write_busy_i;
    stat_word[ST_WIN_BIT] = win_open;
  end

  assign rd_word = rd_ctrl_hit ? {27'h0000000, ctrl_ff} :
                   rd_stat_hit ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Arming and windows
  // ----------------------------------------------------------------
  // EEPROM write blocks arming
  // ignored write is the safety net if software skips the check
  wire logic arm = wr_fire & wr_ctrl_hit & wstrb0_ff & pat_ok &
                   ~eeprom_write_busy_i & ~busy_ff;
  wire logic spm_win = win_cnt_ff < SPM_WIN;
  wire logic lpm_win = win_cnt_ff < LPM_WIN;
  // store acts only inside the window
  // store outside the window is dropped
  wire logic spm_ok = store_program_instr_i & win_open & spm_win & ~eeprom_write_busy_i;
  wire logic lpm_ok = load_program_instr_i & win_open & ctrl_ff[FREAD_BIT] &
                      lpm_win & ~eeprom_write_busy_i;
  wire logic page_op = ctrl_ff[WRITE_BIT] | ctrl_ff[ERASE_BIT];
  wire logic start_op = spm_ok & page_op;
  wire logic load_word = spm_ok & (ctrl_ff == PAT_LOAD);
  // fuse read gives up after three cycles
  wire logic fread_tmo = ctrl_ff[FREAD_BIT] & (win_cnt_ff == LPM_WIN - 3'h1);
  wire logic spm_tmo = win_open & (win_cnt_ff == SPM_WIN - 3'h1);
  // RC ticks set the length, the cycle cap bounds it
  wire logic op_done = busy_ff & ((rc_cnt_ff >= PROG_RC_TICKS) | (cyc_cnt_ff >= PROG_MAX_CYC));

  logic [CTRL_W-1:0] nxt_ctrl;
  always_comb begin
    if (arm) begin
      nxt_ctrl = wr_pat;
    end else if (op_done) begin
      nxt_ctrl = CTRL_RST;
    end else if (busy_ff | start_op) begin
      nxt_ctrl = ctrl_ff;
    end else if (spm_ok | lpm_ok | fread_tmo | spm_tmo) begin
      nxt_ctrl = CTRL_RST;
    end else begin
      nxt_ctrl = ctrl_ff;
    end
  end

  // stored bits are inverted so programmed reads zero
  // fuse low byte at pointer 0x0000
  // fuse high byte at pointer 0x0003
  wire logic [7:0] fuse_byte = (pointer_i == PTR_LOCK) ? ~sync2_ff[23:16] :
                               (pointer_i == PTR_FUSE_LO) ? ~sync2_ff[7:0] :
                               (pointer_i == PTR_FUSE_HI) ? ~sync2_ff[15:8] : UNPROG_BYTE;

  // buffer erased after page write and on reset
  wire logic nxt_buf_clear = (arm & (wr_pat == PAT_BCLR)) | (op_done & op_write_ff);

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
      awaddr_ff <= CTRL_OFS;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OK;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata_i;
        wstrb0_ff <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        bresp_ff <= wr_mapped ? RESP_OK : RESP_DECERR;
      end
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= (rd_ctrl_hit | rd_stat_hit) ? RESP_OK : RESP_DECERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits and window counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i && !busy_ff) begin
      ctrl_ff <= CTRL_RST;
      win_cnt_ff <= 3'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (arm) begin
        win_cnt_ff <= 3'h0;
      end else if (win_open && spm_win) begin
        win_cnt_ff <= win_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash operation
  // ----------------------------------------------------------------
  // Reset is ignored while busy so an operation already under way
  // finishes instead of leaving a half-programmed page. The busy test
  // comes first so an unknown power-up busy still falls into reset.
  always_ff @(posedge ref_clk_i) begin
    if (busy_ff) begin
      if (op_done) begin
        busy_ff <= 1'b0;
        op_write_ff <= 1'b0;
      end else begin
        cyc_cnt_ff <= cyc_cnt_ff + TMR_W'(1);
        if (rc_tick) begin
          rc_cnt_ff <= rc_cnt_ff + TMR_W'(1);
        end
      end
    end else if (!rst_b_i) begin
      busy_ff <= 1'b0;
      op_write_ff <= 1'b0;
      page_ff <= '0;
      rc_cnt_ff <= '0;
      cyc_cnt_ff <= '0;
    end else if (start_op) begin
      busy_ff <= 1'b1;
      op_write_ff <= ctrl_ff[WRITE_BIT];
      page_ff <= pointer_i[PTR_W-1:PAGE_WORD_BITS+1];
      rc_cnt_ff <= '0;
      cyc_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Buffer, readback and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      buf_wr_ff <= 1'b0;
      buf_word_ff <= '0;
      buf_data_ff <= 16'h0000;
      buf_clear_ff <= 1'b1;
      load_valid_ff <= 1'b0;
      load_data_ff <= UNPROG_BYTE;
    end else begin
      buf_wr_ff <= load_word;
      if (load_word) begin
        buf_word_ff <= pointer_i[PAGE_WORD_BITS:1];
        buf_data_ff <= data_word_pair_i;
      end
      buf_clear_ff <= nxt_buf_clear;
      load_valid_ff <= lpm_ok;
      if (lpm_ok) begin
        load_data_ff <= fuse_byte;
      end
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign cpu_stall_o = busy_ff;
  assign load_valid_o = load_valid_ff;
  assign load_data_o = load_data_ff;
  assign buf_wr_o = buf_wr_ff;
  assign buf_word_o = buf_word_ff;
  assign buf_data_o = buf_data_ff;
  assign buf_clear_o = buf_clear_ff;
  assign flash_erase_o = busy_ff & ~op_write_ff;
  assign flash_write_o = busy_ff & op_write_ff;
  assign flash_page_o = page_ff;

endmodule

/* test/flash_seq_chk.sv */
// Port checker for the flash self-programming sequencer.
// Assumes it is bound to the design and the fuse inputs stay steady.
`timescale 1ns/1ps
module flash_seq_chk
  import flash_seq_pkg::*;
#(
  parameter logic [TMR_W-1:0] PROG_RC_TICKS = TMR_W'(20),
  parameter logic [TMR_W-1:0] PROG_MAX_CYC = TMR_W'(40)
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic store_program_instr_i,
  input wire logic load_program_instr_i,
  input wire logic [PTR_W-1:0] pointer_i,
  input wire logic [15:0] data_word_pair_i,
  input wire logic eeprom_write_busy_i,
  input wire logic [7:0] fuse_low_prog_i,
  input wire logic [7:0] fuse_high_prog_i,
  input wire logic [7:0] lock_prog_i,
  input wire logic cpu_stall_o,
  input wire logic load_valid_o,
  input wire logic [7:0] load_data_o,
  input wire logic buf_wr_o,
  input wire logic [PAGE_WORD_BITS-1:0] buf_word_o,
  input wire logic [15:0] buf_data_o,
  input wire logic buf_clear_o,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic [PAGE_W-1:0] flash_page_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Stall length; counts through reset since operations outlive it
  logic [TMR_W-1:0] stall_cnt_ff;
  always_ff @(posedge ref_clk_i) begin
    stall_cnt_ff <= cpu_stall_o ? stall_cnt_ff + 1'b1 : '0;
  end
  property p_buf_load;
    buf_wr_o |-> $past(store_program_instr_i) && buf_word_o == $past(pointer_i[5:1])
      && buf_data_o == $past(data_word_pair_i);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer load wrong");
  property p_op_page;
    $rose(flash_write_o) || $rose(flash_erase_o) |->
      $past(store_program_instr_i) && flash_page_o == $past(pointer_i[15:6]);
  endproperty
  a_op_page: assert property (p_op_page) else $error("flash page wrong");
  property p_op_stall;
    flash_write_o || flash_erase_o |-> cpu_stall_o;
  endproperty
  a_op_stall: assert property (p_op_stall) else $error("core not halted");
  property p_ee_block;
    eeprom_write_busy_i && (store_program_instr_i || load_program_instr_i) |=>
      !buf_wr_o && !load_valid_o && !$rose(cpu_stall_o);
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("eeprom busy ignored");
  property p_clr_after_wr;
    $fell(flash_write_o) |-> ##[0:1] buf_clear_o;
  endproperty
  a_clr_after_wr: assert property (p_clr_after_wr) else $error("no clear");
  property p_lock_rd;
    load_valid_o && $past(pointer_i) == PTR_LOCK |-> load_data_o == ~lock_prog_i;
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock byte wrong");
  property p_flo_rd;
    load_valid_o && $past(pointer_i) == PTR_FUSE_LO |-> load_data_o == ~fuse_low_prog_i;
  endproperty
  a_flo_rd: assert property (p_flo_rd) else $error("fuse low wrong");
  property p_fhi_rd;
    load_valid_o && $past(pointer_i) == PTR_FUSE_HI |-> load_data_o == ~fuse_high_prog_i;
  endproperty
  a_fhi_rd: assert property (p_fhi_rd) else $error("fuse high wrong");
  property p_op_max;
    cpu_stall_o |-> stall_cnt_ff <= PROG_MAX_CYC + 2;
  endproperty
  a_op_max: assert property (p_op_max) else $error("operation too long");
  property p_op_min;
    $fell(cpu_stall_o) |-> $past(stall_cnt_ff) >= PROG_RC_TICKS;
  endproperty
  a_op_min: assert property (p_op_min) else $error("operation too short");
  property p_rsv;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:5] == '0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  c_load: cover property (buf_wr_o);
  c_erase: cover property ($rose(flash_erase_o));
  c_write: cover property ($rose(flash_write_o));
  c_fuse: cover property (load_valid_o);
endmodule

bind self_program_flash_sequencer flash_seq_chk #(
  .PROG_RC_TICKS(PROG_RC_TICKS),
  .PROG_MAX_CYC(PROG_MAX_CYC)
) u_chk (.ref_clk_i, .rst_b_i, .store_program_instr_i, .load_program_instr_i, .pointer_i,
  .data_word_pair_i, .eeprom_write_busy_i, .fuse_low_prog_i, .fuse_high_prog_i, .lock_prog_i,
  .cpu_stall_o, .load_valid_o, .load_data_o, .buf_wr_o, .buf_word_o, .buf_data_o, .buf_clear_o,
  .flash_erase_o, .flash_write_o, .flash_page_o, .s_axi_rvalid_o, .s_axi_rdata_o);

/* test/cpu_model.sv */
// Core model issuing store and load program instructions.
// Assumes callers time each issue against the enable window.
`timescale 1ns/1ps
module cpu_model
  import flash_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic cpu_stall_i,
  output logic store_o,
  output logic load_o,
  output logic [PTR_W-1:0] pointer_o,
  output logic [15:0] data_o
);
  initial begin
    store_o = 1'b0;
    load_o = 1'b0;
    pointer_o = '0;
    data_o = '0;
  end
  // issued as soon as the core is not stalled, so a caller can land inside the window
  task automatic issue(input logic is_load, input logic [PTR_W-1:0] p, input logic [15:0] d);
    for (int n = 0; n < 200 && cpu_stall_i; n++) begin
      @(posedge ref_clk_i);
    end
    store_o <= !is_load;
    load_o <= is_load;
    pointer_o <= p;
    data_o <= d;
    @(posedge ref_clk_i);
    // Operands do not linger after the pulse
    store_o <= 1'b0;
    load_o <= 1'b0;
    pointer_o <= ~p;
    data_o <= ~d;
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench: bus master, core partner and result watcher.
// Assumes the checker is bound and short programming counts are set.
`timescale 1ns/1ps
module tb_top
  import flash_seq_pkg::*;
;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, rc_clk_i = 1'b0, ee = 1'b0, live_ff = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = '0, ara = '0, flo, fhi, lck;
  logic [31:0] wd = '0;
  logic awr, wr_rdy, bv, arr, rv, stall, st, ld, lv, bw, bc, fe, fw;
  logic [1:0] br, rr, op_ff = '0;
  logic [31:0] rd;
  logic [7:0] ldd;
  logic [4:0] bwd;
  logic [15:0] bdat, dat;
  logic [9:0] pg;
  logic [15:0] ptr, p;
  logic [33:0] q[6][$];
  string nm[6] = '{"buffer", "load", "flash op", "read", "write resp", "clear"};
  int n_errors = 0, checks_done = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  always #7.5 rc_clk_i = ~rc_clk_i;
  cpu_model cpu (.ref_clk_i(ref_clk_i), .cpu_stall_i(stall), .store_o(st), .load_o(ld),
    .pointer_o(ptr), .data_o(dat));
  self_program_flash_sequencer #(.PROG_RC_TICKS(20), .PROG_MAX_CYC(40)) uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .s_axi_awvalid_i(awv), .s_axi_awaddr_i(awa),
    .s_axi_awready_o(awr), .s_axi_wvalid_i(wv), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wready_o(wr_rdy), .s_axi_bvalid_o(bv), .s_axi_bresp_o(br), .s_axi_bready_i(bry),
    .s_axi_arvalid_i(arv), .s_axi_araddr_i(ara), .s_axi_arready_o(arr), .s_axi_rvalid_o(rv),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rready_i(rry), .store_program_instr_i(st),
    .load_program_instr_i(ld), .pointer_i(ptr), .data_word_pair_i(dat),
    .eeprom_write_busy_i(ee), .cpu_stall_o(stall), .load_valid_o(lv), .load_data_o(ldd),
    .buf_wr_o(bw), .buf_word_o(bwd), .buf_data_o(bdat), .buf_clear_o(bc),
    .flash_erase_o(fe), .flash_write_o(fw), .flash_page_o(pg), .rc_clk_i(rc_clk_i),
    .fuse_low_prog_i(flo), .fuse_high_prog_i(fhi), .lock_prog_i(lck));
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic take(input int k, input logic [33:0] g);
    if (q[k].size() == 0) chk(nm[k], 'x, g);
    else chk(nm[k], q[k].pop_front(), g);
  endtask
  // Reset and the edge after it are skipped: outputs still settle there
  always @(posedge ref_clk_i) begin
    live_ff <= rst_b_i;
    op_ff <= {fw, fe};
    if (live_ff && rst_b_i) begin
      if (bw) take(0, {bwd, bdat});
      if (lv) take(1, ldd);
      if ({fw, fe} != 2'b00 && op_ff == 2'b00) take(2, {fw, fe, pg});
      if (rv && rry) take(3, {rr, rd});
      if (bv && bry) take(4, br);
      if (bc) take(5, '0);
    end
  end
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] e);
    int n;
    q[w ? 4 : 3].push_back(e);
    @(posedge ref_clk_i);
    if (w) begin
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    end else begin
      arv <= 1'b1; ara <= a; rry <= 1'b1;
    end
    for (n = 0; n < 300; n++) begin
      @(posedge ref_clk_i);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      if (bv || rv) break;
    end
    bry <= 1'b0;
    rry <= 1'b0;
    if (n == 300) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr_ctrl(input logic [4:0] v);
    bus(1'b1, CTRL_OFS, {27'h0, v}, RESP_OK);
  endtask
  task automatic rd_ctrl(input logic [4:0] v);
    bus(1'b0, CTRL_OFS, '0, {RESP_OK, 27'h0, v});
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 200 && stall !== 1'b0; n++) @(posedge ref_clk_i);
    if (n == 200) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // One page operation; a reset may land in its middle
  task automatic page_op(input logic [4:0] pat, input logic [1:0] kind, input bit mid_rst);
    p = 16'($urandom);
    q[2].push_back({kind, p[15:6]});
    if (kind[1]) q[5].push_back('0);
    wr_ctrl(pat);
    cpu.issue(1'b0, p, 16'($urandom));
    if (mid_rst) begin
      repeat (5) @(posedge ref_clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chk("stall in reset", 1'b1, stall);
      rst_b_i <= 1'b1;
    end else rd_ctrl(pat);
    wait_idle();
    rd_ctrl(5'h00);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68));
    {flo, fhi, lck} = 24'($urandom);
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd_ctrl(CTRL_RST);
    bus(1'b1, 8'h08, 32'h1F, RESP_DECERR);
    rd_ctrl(5'h00);
    $display("done reset and map");
    for (int i = 0; i < 6; i++) begin
      p = 16'($urandom);
      wr_ctrl(PAT_LOAD);
      repeat (i % 4) @(posedge ref_clk_i);
      // store accepted only in window cycles 1..3
      if (i % 4 < 3) q[0].push_back({p[5:1], 16'(p ^ 16'h5A5A)});
      cpu.issue(1'b0, p, p ^ 16'h5A5A);
      rd_ctrl(5'h00);
    end
    $display("done page load");
    for (int i = 0; i < 32; i++) begin
      if (!(i inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})) begin
        wr_ctrl(5'(i));
        cpu.issue(1'b0, 16'($urandom), 16'($urandom));
        rd_ctrl(5'h00);
      end
    end
    $display("done ignored patterns");
    q[5].push_back('0);
    wr_ctrl(PAT_BCLR);
    cpu.issue(1'b0, 16'h0000, 16'h0000);
    page_op(PAT_ERASE, 2'b01, 1'b0);
    page_op(PAT_WRITE, 2'b10, 1'b0);
    page_op(PAT_WRITE, 2'b10, 1'b1);
    $display("done page operations");
    foreach (p[i]) begin
      if (i < 5) begin
        p = (i == 4) ? 16'h0000 : {14'h0, 2'(i)};
        wr_ctrl(PAT_FREAD);
        repeat (i % 3) @(posedge ref_clk_i);
        // load counts in window cycles 1..2
        if (i % 3 < 2) q[1].push_back(p == 0 ? ~flo : p == 1 ? ~lck : p == 3 ? ~fhi : 8'hFF);
        cpu.issue(1'b1, p, '0);
        rd_ctrl(5'h00);
      end
    end
    $display("done fuse reads");
    ee <= 1'b1;
    // software sees the eeprom busy flag before touching control
    bus(1'b0, STAT_OFS, '0, {RESP_OK, 32'h2});
    wr_ctrl(PAT_LOAD);
    cpu.issue(1'b0, 16'($urandom), 16'($urandom));
    wr_ctrl(PAT_FREAD);
    cpu.issue(1'b1, PTR_LOCK, '0);
    ee <= 1'b0;
    rd_ctrl(5'h00);
    $display("done eeprom block");
    repeat (4) @(posedge ref_clk_i);
    foreach (q[k]) chk({nm[k], " left over"}, '0, q[k].size());
    give_verdict();
  end
endmodule
